/* shared/zgc_pkg.sv */
// Purpose: Constants and types for the gain and conversion controller
// Assumes: 100 MHz REF_CLK, 4 MHz oscillator derived from it
// Notes: Byte addresses, registers in the low lanes, at most 8-bit except the 16-bit result
package zgc_pkg;
    localparam logic [7:0] ADDR_CFG0 = 8'h00;
    localparam logic [7:0] ADDR_ENABLE = 8'h04;
    localparam logic [7:0] ADDR_RATE = 8'h08;
    localparam logic [7:0] ADDR_GAIN = 8'h0C;
    localparam logic [7:0] ADDR_FOFF = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_RESULT = 8'h1C;
    localparam int CFG0_RATIO_LSB = 2;
    localparam int CFG0_ELEM_LSB = 5;
    localparam int CFG0_CONTINUOUS_MODE_BIT_BIT = 7;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_DEF_BIT = 1;
    localparam int CTRL_BG_LSB = 2;
    localparam int RATE_FIN_LSB = 6;
    localparam int RATE_MGAIN_LSB = 4;
    localparam int RATE_MOFF_SIGN = 3;
    localparam int GAIN_COARSE_BIT = 7;
    localparam int FOFF_SIGN_BIT = 6;
    localparam logic [7:0] RST_CFG0 = 8'h28;
    localparam logic [3:0] RST_ENABLE = 4'h1;
    localparam logic [7:0] RST_RATE = 8'hC0;
    localparam logic [7:0] RST_GAIN = 8'h00;
    localparam logic [6:0] RST_FOFF = 7'h00;
    localparam logic [1:0] RST_BG = 2'h0;
    localparam logic [2:0] MOFF_MAX = 3'h5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int REF_CLK_HZ = 100_000_000;
    localparam int OSC_HZ = 4_000_000;
    localparam int OSC_DIV = REF_CLK_HZ / OSC_HZ;
    localparam logic [4:0] OSC_LAST = 5'(OSC_DIV - 1);
    localparam logic [5:0] FS_LIM_SLOW = 6'h3F;
    localparam logic [10:0] OSR_BASE = 11'h008;
    localparam logic [3:0] SETUP_CYC = 4'h2;
    localparam logic [3:0] END_CYC = 4'h2;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_CONV, ST_QUANT, ST_END
    } zgc_state_type;
    typedef enum logic [1:0] {
        BG_LOW, BG_HIGH, BG_TOG1, BG_TOG2
    } zgc_bg_type;
endpackage : zgc_pkg

/* rtl/zgc_ctrl.sv */
// Purpose: Gain/offset decode and conversion sequencer, AXI4-Lite slave
// Assumes: MOD_BIT is asynchronous to REF_CLK
// Notes: All outputs registered
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Enable field bit0 modulator, bits 1..3 amplifier stages one to three
// - A disabled amplifier stage is bypassed to the next stage
// - Coarse gain select: 0 gives unity, 1 gives gain 10
// - Medium gain code 00,01,10,11 gives 1,2,5,10
// - Medium offset is sign-magnitude, magnitude 0..5 in 0.2 steps
// - Fine gain code is unsigned twelfths, zero to 127/12
// - Fine offset sign-magnitude twelfths, negative zero gives zero
// - Start or restore-defaults bit begins a new conversion every time
// - Conversion is N elementary conversions then one final quantization
// - Each elementary conversion lasts ratio plus one sampling periods
// - Result is the mean of the elementary results
// - Offset polarity reverses on alternate elementary conversions
// - A few extra clocks are added before and after each sequence
// - Bandgap state held high, low, or toggled each elementary conversion or every second one
// - Sampling rate select gives 62.5, 125, 250 or 500 kHz
// - Ratio is two to the power three plus 3-bit code
// - Elementary count is two to the power of 2-bit code
// - Busy flag reads one while a sequence runs
// - Continuous mode restarts a conversion as soon as one finishes
module zgc_ctrl import zgc_pkg::*; (
    input wire logic REF_CLK,                 // System clock
    input wire logic RST_B,                   // Async reset, low
    input wire logic [7:0] S_AXI_AWADDR,      // Write address
    input wire logic S_AXI_AWVALID,           // Write address valid
    output logic S_AXI_AWREADY,               // Write address ready
    input wire logic [31:0] S_AXI_WDATA,      // Write data
    input wire logic [3:0] S_AXI_WSTRB,       // Byte enables
    input wire logic S_AXI_WVALID,            // Write data valid
    output logic S_AXI_WREADY,                // Write data ready
    output logic [1:0] S_AXI_BRESP,           // Write response
    output logic S_AXI_BVALID,                // Write response valid
    input wire logic S_AXI_BREADY,            // Write response ready
    input wire logic [7:0] S_AXI_ARADDR,      // Read address
    input wire logic S_AXI_ARVALID,           // Read address valid
    output logic S_AXI_ARREADY,               // Read address ready
    output logic [31:0] S_AXI_RDATA,          // Read data
    output logic [1:0] S_AXI_RRESP,           // Read response
    output logic S_AXI_RVALID,                // Read data valid
    input wire logic S_AXI_RREADY,            // Read data ready
    input wire logic MOD_BIT,                 // Modulator bitstream
    output logic MOD_EN,                      // Modulator enable
    output logic [2:0] STAGE_EN,              // Stage 1..3 enables
    output logic [2:0] STAGE_BYPASS,          // Stage 1..3 bypass
    output logic COARSE_GAIN_X10,             // Stage 1 gain of 10
    output logic [3:0] MEDIUM_GAIN,           // Stage 2 gain value
    output logic MEDIUM_OFFSET_NEG,           // Stage 2 offset sign
    output logic [2:0] MEDIUM_OFFSET_MAG,     // Stage 2 offset, 0.2 units
    output logic [6:0] FINE_GAIN,             // Stage 3 gain, twelfths
    output logic FINE_OFFSET_NEG,             // Stage 3 offset sign
    output logic [5:0] FINE_OFFSET_MAG,       // Stage 3 offset, twelfths
    output logic OS_TICK,                     // Sampling period strobe
    output logic CHOP,                        // Offset polarity
    output logic BANDGAP_STATE,               // Bandgap state
    output logic BUSY,                        // Sequence running
    output logic CONV_DONE,                   // One-cycle done pulse
    output logic [15:0] RESULT                // Averaged result
);
    logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
    logic arready_q, rvalid_q;
    logic [7:0] awaddr_q, wdata_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic wstrb_q;
    logic [7:0] cfg0_q, rate_q, gain_q;
    logic [3:0] en_q;
    logic [6:0] foff_q;
    logic [1:0] bg_mode_q;
    zgc_state_type state_q, state_d;
    logic [3:0] step_q, elem_q;
    logic [10:0] per_q;
    logic [13:0] acc_q;
    logic [2:0] ratio_q;
    logic [1:0] ecode_q;
    logic [4:0] osc_q;
    logic [5:0] fs_q;
    logic sync1_q, sync2_q, sync3_q, mod_q;
    logic chop_q, bg_q, busy_q, done_q, tick_q;
    logic [15:0] result_q;

    // Write channel: address and data accepted independently
    wire aw_take = S_AXI_AWVALID & awready_q;
    wire w_take = S_AXI_WVALID & wready_q;
    wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
    wire aw_full_d = (aw_full_q | aw_take) & ~wr_go;
    wire w_full_d = (w_full_q | w_take) & ~wr_go;
    wire wr_en = wr_go & wstrb_q;
    wire sel_cfg0 = awaddr_q == ADDR_CFG0;
    wire sel_en = awaddr_q == ADDR_ENABLE;
    wire sel_rate = awaddr_q == ADDR_RATE;
    wire sel_gain = awaddr_q == ADDR_GAIN;
    wire sel_foff = awaddr_q == ADDR_FOFF;
    wire sel_ctrl = awaddr_q == ADDR_CTRL;
    wire wr_known = sel_cfg0 | sel_en | sel_rate | sel_gain | sel_foff
        | sel_ctrl;
    wire start_wr = wr_en & sel_ctrl & wdata_q[CTRL_START_BIT];
    wire def_wr = wr_en & sel_ctrl & wdata_q[CTRL_DEF_BIT];
    wire continuous_mode_bit_wr = wr_en & sel_cfg0 & wdata_q[CFG0_CONTINUOUS_MODE_BIT_BIT]
        & ~cfg0_q[CFG0_CONTINUOUS_MODE_BIT_BIT];
    wire start_evt = start_wr | def_wr | continuous_mode_bit_wr;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= ~aw_full_d;
            wready_q <= ~w_full_d;
            bvalid_q <= wr_go | (bvalid_q & ~S_AXI_BREADY);
            if (wr_go) begin
                bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            awaddr_q <= 8'h00;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
        end else begin
            if (aw_take) awaddr_q <= S_AXI_AWADDR;
            if (w_take) begin
                wdata_q <= S_AXI_WDATA[7:0];
                wstrb_q <= S_AXI_WSTRB[0];
            end
        end
    end

    // Restore-defaults reloads every setting as well as starting
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg0_q <= RST_CFG0;
            en_q <= RST_ENABLE;
            rate_q <= RST_RATE;
            gain_q <= RST_GAIN;
            foff_q <= RST_FOFF;
            bg_mode_q <= RST_BG;
        end else if (def_wr) begin
            cfg0_q <= RST_CFG0;
            en_q <= RST_ENABLE;
            rate_q <= RST_RATE;
            gain_q <= RST_GAIN;
            foff_q <= RST_FOFF;
            bg_mode_q <= RST_BG;
        end else if (wr_en) begin
            if (sel_cfg0) cfg0_q <= wdata_q;
            if (sel_en) en_q <= wdata_q[3:0];
            if (sel_rate) rate_q <= wdata_q;
            if (sel_gain) gain_q <= wdata_q;
            if (sel_foff) foff_q <= wdata_q[6:0];
            if (sel_ctrl) bg_mode_q <= wdata_q[CTRL_BG_LSB +: 2];
        end
    end

    // Read channel: one word answered the cycle after acceptance
    wire ar_take = S_AXI_ARVALID & arready_q;
    wire rvalid_d = ar_take | (rvalid_q & ~S_AXI_RREADY);
    wire [7:0] ctrl_rd = {4'h0, bg_mode_q, 2'h0};
    logic [31:0] rd_mux;
    logic rd_known;
    always_comb begin
        rd_known = 1'b1;
        case (S_AXI_ARADDR)
            ADDR_CFG0: rd_mux = {24'h000000, cfg0_q};
            ADDR_ENABLE: rd_mux = {28'h0000000, en_q};
            ADDR_RATE: rd_mux = {24'h000000, rate_q};
            ADDR_GAIN: rd_mux = {24'h000000, gain_q};
            ADDR_FOFF: rd_mux = {25'h0000000, foff_q};
            ADDR_CTRL: rd_mux = {24'h000000, ctrl_rd};
            ADDR_STATUS: rd_mux = {31'h00000000, busy_q};
            ADDR_RESULT: rd_mux = {16'h0000, result_q};
            default: begin
                rd_mux = 32'h00000000;
                rd_known = 1'b0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else begin
            arready_q <= ~rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_take) begin
                rdata_q <= rd_mux;
                rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Oscillator strobe, then sampling strobe
    wire osc_tick = osc_q == OSC_LAST;
    wire [1:0] oversample_rate_sel = rate_q[RATE_FIN_LSB +: 2];
    wire [5:0] fs_lim = FS_LIM_SLOW >> oversample_rate_sel;
    wire fs_tick = osc_tick & (fs_q == fs_lim);
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            osc_q <= 5'h00;
            fs_q <= 6'h00;
            tick_q <= 1'b0;
        end else begin
            osc_q <= osc_tick ? 5'h00 : osc_q + 5'h01;
            if (osc_tick) fs_q <= fs_tick ? 6'h00 : fs_q + 6'h01;
            tick_q <= fs_tick;
        end
    end

    // Three-stage sync; a change is taken once stages two and three agree
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            mod_q <= 1'b0;
        end else begin
            sync1_q <= MOD_BIT;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q) mod_q <= sync3_q;
        end
    end

    // Sequencer; ratio and count latched so mid-run writes cannot skew it
    wire [10:0] osr_val = OSR_BASE << ratio_q;
    wire [3:0] elem_max = 4'((4'h1 << ecode_q) - 4'h1);
    wire per_last = per_q == osr_val;
    wire elem_last = elem_q == elem_max;
    wire conv_tick = (state_q == ST_CONV) & fs_tick;
    wire elem_end = conv_tick & per_last;
    wire end_last = (state_q == ST_END) & (step_q == END_CYC - 4'h1);
    wire continuous_mode_bit_go = end_last & cfg0_q[CFG0_CONTINUOUS_MODE_BIT_BIT];
    wire seq_start = start_evt | continuous_mode_bit_go;
    // Restore starts on the defaults, not on the settings it replaces
    wire [7:0] seq_cfg = def_wr ? RST_CFG0 : cfg0_q;
    wire [1:0] seq_bg = def_wr ? RST_BG : bg_mode_q;
    wire bit_eff = mod_q ^ chop_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: state_d = ST_IDLE;
            ST_SETUP: begin
                if (step_q == SETUP_CYC - 4'h1) state_d = ST_CONV;
            end
            ST_CONV: begin
                if (elem_end && elem_last) state_d = ST_QUANT;
            end
            ST_QUANT: begin
                if (fs_tick) state_d = ST_END;
            end
            ST_END: begin
                if (end_last) state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
        if (seq_start) state_d = ST_SETUP;
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= ST_IDLE;
            step_q <= 4'h0;
            ratio_q <= 3'h0;
            ecode_q <= 2'h0;
        end else begin
            state_q <= state_d;
            step_q <= (seq_start || state_d != state_q) ? 4'h0
                : step_q + 4'h1;
            if (seq_start) begin
                ratio_q <= seq_cfg[CFG0_RATIO_LSB +: 3];
                ecode_q <= seq_cfg[CFG0_ELEM_LSB +: 2];
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            per_q <= 11'h000;
            elem_q <= 4'h0;
            acc_q <= 14'h0000;
        end else if (seq_start) begin
            per_q <= 11'h000;
            elem_q <= 4'h0;
            acc_q <= 14'h0000;
        end else if (conv_tick) begin
            per_q <= per_last ? 11'h000 : per_q + 11'h001;
            if (per_last) elem_q <= elem_q + 4'h1;
            if (bit_eff) acc_q <= acc_q + 14'h0001;
        end
    end

    // Polarity flips at each elementary boundary, bandgap at each or every second one
    wire bg_flip = (bg_mode_q == BG_TOG1) | ((bg_mode_q == BG_TOG2) & chop_q);
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            chop_q <= 1'b0;
            bg_q <= 1'b0;
        end else if (seq_start) begin
            chop_q <= 1'b0;
            bg_q <= seq_bg == BG_HIGH;
        end else begin
            if (elem_end) chop_q <= ~chop_q;
            if (bg_mode_q == BG_LOW) bg_q <= 1'b0;
            else if (bg_mode_q == BG_HIGH) bg_q <= 1'b1;
            else if (elem_end && bg_flip) bg_q <= ~bg_q;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            result_q <= 16'h0000;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            done_q <= end_last;
            busy_q <= state_d != ST_IDLE;
            if (end_last) result_q <= 16'(acc_q >> ecode_q);
        end
    end

    // Stage setting decode
    wire [1:0] mg_code = rate_q[RATE_MGAIN_LSB +: 2];
    wire [3:0] mg_val = mg_code == 2'h0 ? 4'h1 : mg_code == 2'h1 ? 4'h2
        : mg_code == 2'h2 ? 4'h5 : 4'hA;
    // Unlisted magnitudes clamp to the largest step
    wire [2:0] mo_mag = rate_q[2:0] > MOFF_MAX ? MOFF_MAX : rate_q[2:0];
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            MOD_EN <= 1'b0;
            STAGE_EN <= 3'h0;
            STAGE_BYPASS <= 3'h7;
            COARSE_GAIN_X10 <= 1'b0;
            MEDIUM_GAIN <= 4'h1;
            MEDIUM_OFFSET_NEG <= 1'b0;
            MEDIUM_OFFSET_MAG <= 3'h0;
            FINE_GAIN <= 7'h00;
            FINE_OFFSET_NEG <= 1'b0;
            FINE_OFFSET_MAG <= 6'h00;
        end else begin
            MOD_EN <= en_q[0];
            STAGE_EN <= en_q[3:1];
            STAGE_BYPASS <= ~en_q[3:1];
            COARSE_GAIN_X10 <= gain_q[GAIN_COARSE_BIT];
            MEDIUM_GAIN <= mg_val;
            MEDIUM_OFFSET_NEG <= rate_q[RATE_MOFF_SIGN] & |mo_mag;
            MEDIUM_OFFSET_MAG <= mo_mag;
            FINE_GAIN <= gain_q[6:0];
            FINE_OFFSET_NEG <= foff_q[FOFF_SIGN_BIT] & |foff_q[5:0];
            FINE_OFFSET_MAG <= foff_q[5:0];
        end
    end

    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
    assign OS_TICK = tick_q;
    assign CHOP = chop_q;
    assign BANDGAP_STATE = bg_q;
    assign BUSY = busy_q;
    assign CONV_DONE = done_q;
    assign RESULT = result_q;

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    sequence s_last_elem;
        elem_end && elem_last;
    endsequence
    start_setup_a: assert property (start_evt |=> state_q == ST_SETUP)
        else $error("start did not enter setup");
    busy_flag_a: assert property ((state_q != ST_IDLE) |-> BUSY)
        else $error("busy low during sequence");
    period_bound_a: assert property (
        (state_q == ST_CONV) |-> per_q <= osr_val)
        else $error("period count past ratio");
    elem_bound_a: assert property (
        (state_q == ST_CONV) |-> elem_q <= elem_max)
        else $error("too many elementary conversions");
    chop_toggle_a: assert property (
        elem_end && !seq_start |=> CHOP != $past(CHOP))
        else $error("polarity did not alternate");
    quant_step_a: assert property (
        s_last_elem and !seq_start |=> state_q == ST_QUANT)
        else $error("no final quantization");
    done_pulse_a: assert property (CONV_DONE |=> !CONV_DONE)
        else $error("done longer than one cycle");
    // Count code is reloaded on a continuous restart, so use its old value
    done_result_a: assert property (
        end_last |=> CONV_DONE
        && RESULT == 16'($past(acc_q) >> $past(ecode_q)))
        else $error("result or done missing");
    bypass_pair_a: assert property (STAGE_BYPASS == ~STAGE_EN)
        else $error("bypass not inverse of enable");
    fine_zero_a: assert property (
        FINE_OFFSET_MAG == 6'h00 |-> !FINE_OFFSET_NEG)
        else $error("negative zero offset");
    medium_gain_a: assert property (
        mg_code == 2'h2 && !def_wr |=> MEDIUM_GAIN == 4'h5)
        else $error("medium gain decode wrong");
    tick_single_a: assert property (OS_TICK |=> !OS_TICK)
        else $error("sampling tick too long");
endmodule : zgc_ctrl
`default_nettype wire

/* test/zgc_mod_model.sv */
// Purpose: Behavioural modulator for the controller
// Assumes: Bench sets the analog input level as a plain bit
// Notes: Offset polarity flip shows as an inverted bitstream
`timescale 1ns/1ps
`default_nettype none
module zgc_mod_model import zgc_pkg::*; (
    input wire logic clk,     // System clock
    input wire logic rst_b,   // Async reset, low
    input wire logic mod_en,  // Modulator enabled
    input wire logic chop,    // Offset polarity
    input wire logic level,   // Input level set by bench
    output logic mod_bit      // Modulator bitstream
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mod_bit <= 1'b0;
        end else if (mod_en) begin
            mod_bit <= level ^ chop;
        end else begin
            // Disabled modulator gives garbage, never a stale level
            mod_bit <= ~mod_bit;
        end
    end
endmodule : zgc_mod_model
`default_nettype wire

/* test/test_zoom_adc_gain_and_conversion_ctrl.sv */
// Purpose: Self-checking bench for the gain and conversion controller
// Assumes: AXI4-Lite master tasks, modulator model on MOD_BIT
// Notes: Fastest sampling rate keeps conversions short
`timescale 1ns/1ps
`default_nettype none
module test_zoom_adc_gain_and_conversion_ctrl import zgc_pkg::*;;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic level = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, mod_bit, mod_en, coarse;
    logic moff_neg, foff_neg, os_tick, chop, bg, busy, done;
    logic chop_l, bg_l, done_l;
    logic [1:0] bresp, rresp, rr;
    logic [31:0] rdata, rv;
    logic [2:0] stage_en, bypass, moff_mag;
    logic [3:0] mgain;
    logic [6:0] fgain;
    logic [5:0] foff_mag;
    logic [15:0] result;
    int fail_count = 0, check_count = 0;
    int ticks, chop_n, bg_n, done_n, dbl, n;
    logic [31:0] rst_t [8] = '{32'(RST_CFG0), 32'(RST_ENABLE), 32'(RST_RATE),
        32'(RST_GAIN), 32'(RST_FOFF), 0, 0, 0};
    logic [3:0] mg_t [4] = '{4'h1, 4'h2, 4'h5, 4'hA};
    logic [3:0] mo_c [5] = '{4'h0, 4'h5, 4'hD, 4'h8, 4'h9};
    logic [3:0] mo_e [5] = '{4'h0, 4'h5, 4'hD, 4'h0, 4'h9};
    always #5 clk = ~clk;
    zgc_ctrl zgc_ctrl_inst (.REF_CLK(clk), .RST_B(rst_b),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .MOD_BIT(mod_bit),
        .MOD_EN(mod_en), .STAGE_EN(stage_en), .STAGE_BYPASS(bypass),
        .COARSE_GAIN_X10(coarse), .MEDIUM_GAIN(mgain),
        .MEDIUM_OFFSET_NEG(moff_neg), .MEDIUM_OFFSET_MAG(moff_mag),
        .FINE_GAIN(fgain), .FINE_OFFSET_NEG(foff_neg),
        .FINE_OFFSET_MAG(foff_mag), .OS_TICK(os_tick), .CHOP(chop),
        .BANDGAP_STATE(bg), .BUSY(busy), .CONV_DONE(done), .RESULT(result));
    zgc_mod_model zgc_mod_model_inst (.clk(clk), .rst_b(rst_b),
        .mod_en(mod_en), .chop(chop), .level(level), .mod_bit(mod_bit));
    // Sampled mid-cycle so registered outputs have settled
    always @(negedge clk) begin
        if (busy) begin
            ticks += os_tick;
            chop_n += (chop !== chop_l);
            bg_n += (bg !== bg_l);
        end
        done_n += done;
        dbl += (done && done_l);
        chop_l = chop;
        bg_l = bg;
        done_l = done;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        do begin
            @(negedge clk);
            rr = bresp;
        end while (!bvalid);
        @(posedge clk);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        do begin
            @(negedge clk);
            rv = rdata;
            rr = rresp;
        end while (!rvalid);
        @(posedge clk);
        rready <= 1'b0;
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rv, e);
        chk(32'(rr), 32'(RESP_OKAY));
    endtask : rchk
    // Decode outputs land one cycle after the register write
    task automatic wq(input logic [7:0] a, input logic [31:0] d);
        wr(a, d);
        chk(32'(rr), 32'(RESP_OKAY));
        repeat (2) @(negedge clk);
    endtask : wq
    task automatic clr();
        ticks = 0;
        chop_n = 0;
        bg_n = 0;
        done_n = 0;
        dbl = 0;
    endtask : clr
    task automatic conv(input logic [31:0] c, input int nd, lo, hi);
        // Zero means the caller has already started it and cleared counts
        if (c != 0) begin
            clr();
            wr(ADDR_CTRL, c);
        end
        do @(negedge clk); while (done_n < nd);
        chk(32'(ticks >= lo && ticks <= hi), 1);
        chk(32'(dbl), 0);
    endtask : conv
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    initial begin
        #1000000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) rchk(8'(4 * i), rst_t[i]);
        chk({mod_en, bypass, mgain}, {1'b1, 3'h7, 4'h1});
        wr(8'h20, 32'h1);
        chk(32'(rr), 32'(RESP_SLVERR));
        rd(8'h24);
        chk(32'(rr), 32'(RESP_SLVERR));
        for (int i = 0; i < 16; i += 5) begin
            wq(ADDR_ENABLE, 32'(i));
            chk({mod_en, stage_en, bypass}, {i[0], i[3:1], ~i[3:1]});
        end
        for (int i = 0; i < 4; i++) begin
            wq(ADDR_RATE, {24'h0, 2'h3, i[1:0], 4'h0});
            chk(mgain, mg_t[i]);
        end
        for (int i = 0; i < 5; i++) begin
            wq(ADDR_RATE, {28'h00000C, mo_c[i]});
            chk({moff_neg, moff_mag}, mo_e[i]);
        end
        foreach (mo_c[i]) begin
            wq(ADDR_GAIN, 32'h10 * mo_c[i] + 32'(mo_c[i]));
            chk({coarse, fgain}, 8'h11 * mo_c[i]);
            // Stays below 0x80 so the sign bit is always set
            wq(ADDR_FOFF, 32'h40 + 32'(mo_c[i]) * 32'h3);
            chk({foff_neg, foff_mag},
                (mo_c[i] == 0) ? 0 : 7'h40 + mo_c[i] * 3);
        end
        for (int f = 0; f < 4; f++) begin
            wq(ADDR_RATE, {24'h0, f[1:0], 6'h0});
            repeat (2) do @(negedge clk); while (!os_tick);
            n = 0;
            do begin @(negedge clk); n++; end while (!os_tick);
            chk(32'(n), 32'(1600 >> f));
        end
        wq(ADDR_CFG0, 32'h20);
        clr();
        wr(ADDR_CTRL, 32'h1);
        rchk(ADDR_STATUS, 32'h1);
        conv(32'h0, 1, 19, 20);
        chk(32'(chop_n), 2);
        chk(32'(result), 9);
        rchk(ADDR_RESULT, 32'h9);
        rchk(ADDR_STATUS, 32'h0);
        wq(ADDR_CTRL, 32'h4);
        chk(32'(bg), 1);
        wq(ADDR_CTRL, 32'h0);
        chk(32'(bg), 0);
        conv(32'h9, 1, 19, 20);
        chk(32'(bg_n), 32'(chop_n));
        wq(ADDR_CFG0, 32'h40);
        conv(32'hD, 1, 37, 38);
        chk(32'(bg_n * 2), 32'(chop_n));
        chk(32'(chop_n), 4);
        level <= 1'b0;
        clr();
        wq(ADDR_CFG0, 32'hA0);
        do @(negedge clk); while (done_n < 2);
        chk(32'(result), 0);
        wq(ADDR_CFG0, 32'h20);
        do @(negedge clk); while (busy);
        repeat (300) @(negedge clk);
        chk(32'(busy), 0);
        level <= 1'b1;
        wq(ADDR_ENABLE, 32'hF);
        clr();
        wr(ADDR_CTRL, 32'h2);
        rchk(ADDR_ENABLE, 32'h1);
        rchk(ADDR_CFG0, 32'h28);
        rchk(ADDR_STATUS, 32'h1);
        conv(32'h0, 1, 67, 68);
        chk(32'(result), 33);
        tally_and_finish();
    end
endmodule : test_zoom_adc_gain_and_conversion_ctrl
`default_nettype wire
